//--- src/adcrf_top.sv
// Converter control and result formatting registers with their sequencer
//
// Overview of operation
// - Left justified: result bits 9..2 go to high byte bits 7..0.
// - Left justified: result bits 1..0 go to low byte bits 7..6.
// - Left justified: low byte bits 5..0 carry no result data.
// - Right justified: result bits 9..8 go to high byte bits 1..0.
// - Right justified: high byte bits 7..2 carry no result data.
// - Right justified: result bits 7..0 go to low byte bits 7..0.
// - Busy flag set by software while enable is set starts conversion; hardware clears it when done.
`timescale 1ns/1ps
`default_nettype none
module adcrf_top #(
   parameter int RESULT_W = 10
) (
   input  wire logic                mclk_in,
   input  wire logic                rst_n_in,
   input  wire logic [7:0]          addr_in,
   input  wire logic [7:0]          wdata_in,
   input  wire logic                wr_in,
   input  wire logic                rd_in,
   output logic      [7:0]          rdata_out,
   input  wire logic                conv_valid_in,
   input  wire logic [RESULT_W-1:0] conv_data_in,
   output logic                     conv_start_out,
   output logic                     conv_enable_out,
   output logic      [2:0]          conversion_clock_select_out,
   output logic                     negative_reference_select_out,
   output logic      [1:0]          positive_reference_select_out
);

   logic                busy_q;
   logic                enable_q;
   logic                justify_select_q;
   logic [2:0]          clk_sel_q;
   logic                neg_ref_q;
   logic [1:0]          pos_ref_q;
   logic [7:0]          result_high_byte_q;
   logic [7:0]          result_low_byte_q;
   logic                done;
   logic [RESULT_W-1:0] captured;
   logic [7:0]          fmt_high;
   logic [7:0]          fmt_low;
   logic                wr_ctl0;
   logic                wr_ctl1;
   logic [7:0]          ctl0_view;
   logic [7:0]          ctl1_view;
   logic [7:0]          rdata_d;

   assign wr_ctl0 = wr_in && (addr_in == adcrf_pkg::OFS_CONTROL_ZERO);
   assign wr_ctl1 = wr_in && (addr_in == adcrf_pkg::OFS_CONTROL_ONE);

   // ************************************************************
   // Control register zero: enable and busy flag
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         enable_q <= adcrf_pkg::RST_CONTROL_ZERO[adcrf_pkg::BIT_CONV_ENABLE];
      end else if (wr_ctl0) begin
         enable_q <= wdata_in[adcrf_pkg::BIT_CONV_ENABLE];
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         busy_q <= adcrf_pkg::RST_CONTROL_ZERO[adcrf_pkg::BIT_CONV_BUSY];
      end else if (wr_ctl0) begin
         // A software write in the completion cycle wins, so a restart is not lost
         busy_q <= wdata_in[adcrf_pkg::BIT_CONV_BUSY];
      end else if (done || !enable_q) begin
         busy_q <= 1'b0;
      end
   end

   // ************************************************************
   // Control register one: justification, clock and references
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         justify_select_q <= adcrf_pkg::RST_CONTROL_ONE[adcrf_pkg::BIT_JUSTIFY];
         clk_sel_q        <= adcrf_pkg::RST_CONTROL_ONE[adcrf_pkg::CLKSEL_MSB:
                                                        adcrf_pkg::CLKSEL_LSB];
         neg_ref_q        <= adcrf_pkg::RST_CONTROL_ONE[adcrf_pkg::BIT_NEG_REF];
         pos_ref_q        <= adcrf_pkg::RST_CONTROL_ONE[adcrf_pkg::POSREF_MSB:
                                                        adcrf_pkg::POSREF_LSB];
      end else if (wr_ctl1) begin
         justify_select_q <= wdata_in[adcrf_pkg::BIT_JUSTIFY];
         clk_sel_q        <= wdata_in[adcrf_pkg::CLKSEL_MSB:adcrf_pkg::CLKSEL_LSB];
         neg_ref_q        <= wdata_in[adcrf_pkg::BIT_NEG_REF];
         pos_ref_q        <= wdata_in[adcrf_pkg::POSREF_MSB:adcrf_pkg::POSREF_LSB];
      end
   end

   // ************************************************************
   // Conversion sequencer and result formatting
   // ************************************************************
   adcrf_sequencer #(
      .RESULT_W (RESULT_W)
   ) u_seq (
      .mclk_in        (mclk_in),
      .rst_n_in       (rst_n_in),
      .busy_in        (busy_q),
      .enable_in      (enable_q),
      .conv_valid_in  (conv_valid_in),
      .conv_data_in   (conv_data_in),
      .conv_start_out (conv_start_out),
      .done_out       (done),
      .result_out     (captured)
   );

   adcrf_formatter #(
      .RESULT_W (RESULT_W)
   ) u_fmt (
      .result_in     (captured),
      .justify_in    (justify_select_q),
      .high_byte_out (fmt_high),
      .low_byte_out  (fmt_low)
   );

   // ************************************************************
   // Result registers: software writable, loaded on completion
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         result_high_byte_q <= adcrf_pkg::RST_RESULT;
      end else if (done) begin
         result_high_byte_q <= fmt_high;
      end else if (wr_in && (addr_in == adcrf_pkg::OFS_RESULT_HIGH)) begin
         result_high_byte_q <= wdata_in;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         result_low_byte_q <= adcrf_pkg::RST_RESULT;
      end else if (done) begin
         result_low_byte_q <= fmt_low;
      end else if (wr_in && (addr_in == adcrf_pkg::OFS_RESULT_LOW)) begin
         result_low_byte_q <= wdata_in;
      end
   end

   // ************************************************************
   // Read path: data stands only in the cycle after the strobe
   // ************************************************************
   always_comb begin
      ctl0_view = 8'h00;
      ctl0_view[adcrf_pkg::BIT_CONV_BUSY]   = busy_q;
      ctl0_view[adcrf_pkg::BIT_CONV_ENABLE] = enable_q;
      ctl1_view = {justify_select_q, clk_sel_q, 1'b0, neg_ref_q, pos_ref_q}
                  & adcrf_pkg::CONTROL_ONE_MASK;
   end

   always_comb begin
      rdata_d = adcrf_pkg::RST_READ_DATA;
      if (rd_in) begin
         case (addr_in)
            adcrf_pkg::OFS_CONTROL_ZERO: rdata_d = ctl0_view;
            adcrf_pkg::OFS_CONTROL_ONE:  rdata_d = ctl1_view;
            adcrf_pkg::OFS_RESULT_HIGH:  rdata_d = result_high_byte_q;
            adcrf_pkg::OFS_RESULT_LOW:   rdata_d = result_low_byte_q;
            default:                     rdata_d = adcrf_pkg::RST_READ_DATA;
         endcase
      end
   end

   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         rdata_out <= adcrf_pkg::RST_READ_DATA;
      end else begin
         rdata_out <= rdata_d;
      end
   end

   // ************************************************************
   // Settings driven to the analog front end
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         conv_enable_out               <= 1'b0;
         conversion_clock_select_out   <= 3'h0;
         negative_reference_select_out <= 1'b0;
         positive_reference_select_out <= 2'h0;
      end else begin
         conv_enable_out               <= enable_q;
         conversion_clock_select_out   <= clk_sel_q;
         negative_reference_select_out <= neg_ref_q;
         positive_reference_select_out <= pos_ref_q;
      end
   end

endmodule
`default_nettype wire

//--- src/adcrf_pkg.sv
// Constants shared by the converter result formatter design
package adcrf_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 8;
   localparam int RESULT_W = 10;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] OFS_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] OFS_CONTROL_ONE  = 8'h01;
   localparam logic [7:0] OFS_RESULT_HIGH  = 8'h02;
   localparam logic [7:0] OFS_RESULT_LOW   = 8'h03;

   // ************************************************************
   // Control register zero fields
   // ************************************************************
   localparam int BIT_CONV_BUSY   = 1;
   localparam int BIT_CONV_ENABLE = 0;

   // ************************************************************
   // Control register one fields
   // ************************************************************
   localparam int BIT_JUSTIFY     = 7;
   localparam int CLKSEL_MSB      = 6;
   localparam int CLKSEL_LSB      = 4;
   localparam int BIT_NEG_REF     = 2;
   localparam int POSREF_MSB      = 1;
   localparam int POSREF_LSB      = 0;
   localparam logic [7:0] CONTROL_ONE_MASK = 8'hF7;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_CONTROL_ZERO = 8'h00;
   localparam logic [7:0] RST_CONTROL_ONE  = 8'h00;
   localparam logic [7:0] RST_RESULT       = 8'h00;
   localparam logic [7:0] RST_READ_DATA    = 8'h00;

   // ************************************************************
   // Justification encoding
   // ************************************************************
   localparam logic JUSTIFY_LEFT  = 1'b0;
   localparam logic JUSTIFY_RIGHT = 1'b1;

   // ************************************************************
   // Conversion sequencer states, Gray coded along the path
   // ************************************************************
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_REQ  = 2'b01,
      SEQ_WAIT = 2'b11,
      SEQ_LOAD = 2'b10
   } adcrf_seq_state_t;

endpackage

//--- src/adcrf_formatter.sv
// Places a ten bit conversion result into the two result bytes
`timescale 1ns/1ps
`default_nettype none
module adcrf_formatter #(
   parameter int RESULT_W = 10
) (
   input  wire logic [RESULT_W-1:0] result_in,
   input  wire logic                justify_in,
   output logic      [7:0]          high_byte_out,
   output logic      [7:0]          low_byte_out
);

   always_comb begin
      if (justify_in == adcrf_pkg::JUSTIFY_RIGHT) begin
         high_byte_out = {6'h00, result_in[9:8]};
         low_byte_out  = result_in[7:0];
      end else begin
         high_byte_out = result_in[9:2];
         low_byte_out  = {result_in[1:0], 6'h00};
      end
   end

endmodule
`default_nettype wire

//--- src/adcrf_sequencer.sv
// Runs one conversion request and reports its completion
`timescale 1ns/1ps
`default_nettype none
module adcrf_sequencer #(
   parameter int RESULT_W = 10
) (
   input  wire logic                mclk_in,
   input  wire logic                rst_n_in,
   input  wire logic                busy_in,
   input  wire logic                enable_in,
   input  wire logic                conv_valid_in,
   input  wire logic [RESULT_W-1:0] conv_data_in,
   output logic                     conv_start_out,
   output logic                     done_out,
   output logic      [RESULT_W-1:0] result_out
);

   adcrf_pkg::adcrf_seq_state_t state_q;

   // ************************************************************
   // State machine
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         state_q <= adcrf_pkg::SEQ_IDLE;
      end else begin
         case (state_q)
            adcrf_pkg::SEQ_IDLE: begin
               if (busy_in && enable_in) begin
                  state_q <= adcrf_pkg::SEQ_REQ;
               end
            end
            adcrf_pkg::SEQ_REQ: begin
               state_q <= adcrf_pkg::SEQ_WAIT;
            end
            adcrf_pkg::SEQ_WAIT: begin
               // Software dropping busy or enable abandons the conversion
               if (!busy_in || !enable_in) begin
                  state_q <= adcrf_pkg::SEQ_IDLE;
               end else if (conv_valid_in) begin
                  state_q <= adcrf_pkg::SEQ_LOAD;
               end
            end
            adcrf_pkg::SEQ_LOAD: begin
               state_q <= adcrf_pkg::SEQ_IDLE;
            end
            default: begin
               state_q <= adcrf_pkg::SEQ_IDLE;
            end
         endcase
      end
   end

   // ************************************************************
   // Start pulse to the analog front end
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         conv_start_out <= 1'b0;
      end else begin
         conv_start_out <= (state_q == adcrf_pkg::SEQ_IDLE) && busy_in && enable_in;
      end
   end

   // ************************************************************
   // Result capture and completion pulse
   // ************************************************************
   always_ff @(posedge mclk_in) begin
      if (!rst_n_in) begin
         done_out   <= 1'b0;
         result_out <= '0;
      end else begin
         done_out <= (state_q == adcrf_pkg::SEQ_WAIT) && busy_in && enable_in
                     && conv_valid_in;
         if ((state_q == adcrf_pkg::SEQ_WAIT) && conv_valid_in) begin
            result_out <= conv_data_in;
         end
      end
   end

endmodule
`default_nettype wire

//--- test/adcrf_monitor.sv
// Checker of result layout and conversion sequencing at the top ports
`timescale 1ns/1ps
`default_nettype none
module adcrf_monitor #(
   parameter int RESULT_W = 10
) (
   input wire logic                mclk_in,
   input wire logic                rst_n_in,
   input wire logic [7:0]          addr_in,
   input wire logic [7:0]          wdata_in,
   input wire logic                wr_in,
   input wire logic                rd_in,
   input wire logic [7:0]          rdata_out,
   input wire logic                conv_valid_in,
   input wire logic [RESULT_W-1:0] conv_data_in,
   input wire logic                conv_start_out,
   input wire logic                conv_enable_out,
   input wire logic [2:0]          conversion_clock_select_out,
   input wire logic                negative_reference_select_out,
   input wire logic [1:0]          positive_reference_select_out
);
   // ************************************************************
   // Shadow of the result registers
   // ************************************************************
   logic                wait_q, pend_q, just_q, hw_q, rd_hi, rd_lo, wr_busy, wr_c0;
   logic [7:0]          c1_q;
   logic [RESULT_W-1:0] pdat_q, res_q;
   assign wr_c0 = wr_in && addr_in == adcrf_pkg::OFS_CONTROL_ZERO;
   assign wr_busy = wr_c0 && wdata_in[adcrf_pkg::BIT_CONV_BUSY];
   assign rd_hi = rd_in && addr_in == adcrf_pkg::OFS_RESULT_HIGH && hw_q;
   assign rd_lo = rd_in && addr_in == adcrf_pkg::OFS_RESULT_LOW && hw_q;
   always_ff @(posedge mclk_in) begin
      pdat_q <= conv_data_in;
      if (!rst_n_in) begin
         wait_q <= 1'b0;
         pend_q <= 1'b0;
         hw_q   <= 1'b0;
         c1_q   <= 8'h00;
      end else begin
         if (wr_in && addr_in == adcrf_pkg::OFS_CONTROL_ONE) begin
            c1_q <= wdata_in;
         end
         if (conv_start_out) begin
            wait_q <= 1'b1;
         end else if (conv_valid_in || (wr_c0 && wdata_in[1:0] != 2'b11)) begin
            wait_q <= 1'b0;
         end
         pend_q <= wait_q && conv_valid_in;
         if (pend_q) begin
            res_q  <= pdat_q;
            just_q <= c1_q[adcrf_pkg::BIT_JUSTIFY];
            hw_q   <= 1'b1;
         end else if (wr_in && addr_in[7:1] == 7'h01) begin
            hw_q <= 1'b0;
         end
      end
   end
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_left_high: assert property (rd_hi && !just_q |=> rdata_out == $past(res_q[9:2]))
      else $error("left high byte wrong");
   a_left_low: assert property (rd_lo && !just_q |=> rdata_out == {$past(res_q[1:0]), 6'h00})
      else $error("left low byte wrong");
   a_right_high: assert property (rd_hi && just_q |=> rdata_out == {6'h00, $past(res_q[9:8])})
      else $error("right high byte wrong");
   a_right_low: assert property (rd_lo && just_q |=> rdata_out == $past(res_q[7:0]))
      else $error("right low byte wrong");
   a_start_pulse: assert property (conv_start_out |=> !conv_start_out)
      else $error("start pulse too long");
   a_start_cause: assert property (conv_start_out |-> $past(wr_busy, 2))
      else $error("start without busy write");
   a_busy_clears: assert property ($past(pend_q) && wr_c0 == 1'b0 && rd_in && addr_in == 8'h00 |=> !rdata_out[1])
      else $error("busy not cleared");
   a_ctrl_readback: assert property (rd_in && addr_in == 8'h01 |=> rdata_out == ($past(c1_q) & 8'hF7))
      else $error("control one readback wrong");
   c_left_load: cover property (pend_q && !c1_q[7]);
   c_right_load: cover property (pend_q && c1_q[7]);
   c_start: cover property (conv_start_out);
endmodule
bind adcrf_top adcrf_monitor #(.RESULT_W(RESULT_W)) u_mon (
   .mclk_in(mclk_in),
   .rst_n_in(rst_n_in),
   .addr_in(addr_in),
   .wdata_in(wdata_in),
   .wr_in(wr_in),
   .rd_in(rd_in),
   .rdata_out(rdata_out),
   .conv_valid_in(conv_valid_in),
   .conv_data_in(conv_data_in),
   .conv_start_out(conv_start_out),
   .conv_enable_out(conv_enable_out),
   .conversion_clock_select_out(conversion_clock_select_out),
   .negative_reference_select_out(negative_reference_select_out),
   .positive_reference_select_out(positive_reference_select_out)
);
`default_nettype wire

//--- test/adc_result_formatter_tb_top.sv
// Self-checking bench for the converter result formatter
`timescale 1ns/1ps
`default_nettype none
module adc_result_formatter_tb_top;
   logic       mclk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   logic       conv_valid_in = 1'b0;
   logic [9:0] conv_data_in = 10'h000;
   logic [7:0] rdata_out, got;
   logic       conv_start_out, conv_enable_out, neg_ref;
   logic [2:0] clk_sel;
   logic [1:0] pos_ref;
   int         fail_count = 0;
   int         n_checks = 0;
   int         d, v, e_hi, e_lo;
   int         exp_q[$];
   always #12.5 mclk_in = ~mclk_in;
   adcrf_top DUT (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .conv_valid_in(conv_valid_in), .conv_data_in(conv_data_in),
      .conv_start_out(conv_start_out), .conv_enable_out(conv_enable_out),
      .conversion_clock_select_out(clk_sel), .negative_reference_select_out(neg_ref),
      .positive_reference_select_out(pos_ref));
   // ************************************************************
   // Bus and check tasks
   // ************************************************************
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] g, input logic [7:0] e, input string what);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
      end
   endtask
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] dt);
      @(posedge mclk_in);
      addr_in <= a;
      wdata_in <= dt;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic bus_rd(input logic [7:0] a, output logic [7:0] dt);
      @(posedge mclk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      dt = rdata_out;
   endtask
   task automatic start_conv();
      int i;
      bus_wr(8'h00, 8'h03);
      for (i = 0; i < 8 && conv_start_out !== 1'b1; i++)
         @(negedge mclk_in);
      if (i == 8) begin
         fail_count++;
         $display("[ERR] %0t no start pulse", $time);
         complete_run();
      end
      @(negedge mclk_in);
      check({7'h00, conv_start_out}, 8'h00, "start width");
   endtask
   task automatic pulse_valid(input int dt, input int dly);
      repeat (dly + 1) @(posedge mclk_in);
      conv_valid_in <= 1'b1;
      conv_data_in <= dt[9:0];
      @(posedge mclk_in);
      conv_valid_in <= 1'b0;
      conv_data_in <= ~dt[9:0];
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      v = $urandom(64066);
      repeat (6) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (v = 0; v < 5; v++) begin
         bus_rd(v[7:0], got);
         check(got, 8'h00, "reset value");
      end
      $display("test reset done");
      for (v = 0; v < 4; v++) begin
         d = $urandom;
         bus_wr(8'h01, d[7:0]);
         bus_wr(8'h40, ~d[7:0]);
         bus_rd(8'h01, got);
         check(got, d[7:0] & 8'hF7, "control one");
         check({clk_sel, neg_ref, pos_ref, 2'b00}, {d[6:4], d[2], d[1:0], 2'b00}, "selects");
         bus_rd(8'h40, got);
         check(got, 8'h00, "unmapped");
      end
      $display("test control done");
      for (v = 0; v < 8; v++) begin
         d = (v == 0) ? 32'h3FF : (v == 1) ? 32'h0 : ($urandom & 32'h3FF);
         bus_wr(8'h01, {v[0], 7'h25});
         start_conv();
         pulse_valid(d, $urandom % 4);
         bus_rd(8'h00, got);
         check(got, 8'h01, "busy cleared");
         // Reference layout from the justify bit, queued high then low
         exp_q.push_back(v[0] ? d >> 8 : d >> 2);
         exp_q.push_back(v[0] ? d & 255 : (d & 3) << 6);
         e_hi = exp_q.pop_front();
         e_lo = exp_q.pop_front();
         bus_rd(8'h02, got);
         check(got, e_hi[7:0], "high byte");
         bus_rd(8'h03, got);
         check(got, e_lo[7:0], "low byte");
      end
      $display("test conversion done");
      bus_wr(8'h02, 8'hA5);
      bus_wr(8'h03, 8'h5A);
      start_conv();
      bus_wr(8'h00, 8'h01);
      pulse_valid(32'h155, 0);
      pulse_valid(32'h2AA, 2);
      bus_rd(8'h00, got);
      check(got, 8'h01, "aborted busy");
      bus_rd(8'h02, got);
      check(got, 8'hA5, "kept high");
      bus_rd(8'h03, got);
      check(got, 8'h5A, "kept low");
      check({7'h00, conv_enable_out}, 8'h01, "enable copy");
      // Dropping enable mid conversion forces busy low and keeps results
      start_conv();
      bus_wr(8'h00, 8'h02);
      pulse_valid(32'h0F0, 0);
      bus_rd(8'h00, got);
      check(got, 8'h00, "enable drop busy");
      bus_rd(8'h03, got);
      check(got, 8'h5A, "kept after drop");
      check({7'h00, conv_enable_out}, 8'h00, "enable off");
      $display("test abort done");
      // Reset in mid run, with a write that reset must override
      @(posedge mclk_in);
      rst_n_in <= 1'b0;
      bus_wr(8'h01, 8'hFF);
      repeat (2) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (v = 0; v < 4; v++) begin
         bus_rd(v[7:0], got);
         check(got, 8'h00, "mid-run reset");
      end
      check({clk_sel, neg_ref, pos_ref, 2'b00}, 8'h00, "selects reset");
      $display("test mid-run reset done");
      complete_run();
   end
   initial begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      $display("[ERR] %0t run too long", $time);
      complete_run();
   end
endmodule
`default_nettype wire
